// ===== dpt_channel.sv
// dma channel progress tracking: positions, cell counter, pattern clear, buffer, wishbone slave
`timescale 1ns/1ps
`default_nettype none

module dpt_channel
  import dpt_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = BUF_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic trigger,
  input wire logic src_valid,
  output logic src_ready,
  input wire logic [WIDTH-1:0] src_data,
  output logic dst_valid,
  input wire logic dst_ready,
  output logic [WIDTH-1:0] dst_data,
  output logic pattern_match,
  output logic cell_done,
  output logic source_done,
  output logic destination_done
);

  // ==========================================================
  // registers
  logic [15:0] source_size_r;
  logic [15:0] destination_size_r;
  logic [15:0] cell_size_r;
  logic [7:0] pattern_match_value_r;
  logic pattern_mode_r;
  logic [15:0] source_position_r;
  logic [15:0] destination_position_r;
  logic [15:0] cell_progress_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic pattern_match_r;
  logic cell_done_r;
  logic source_done_r;
  logic destination_done_r;

  // ==========================================================
  // buffer storage
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PTR_W-1:0] wptr_r;
  logic [PTR_W-1:0] rptr_r;
  logic [PTR_W:0] count_r;

  // bus request decode
  logic wb_req;
  logic wb_wr;
  logic src_fire;
  logic dst_fire;
  logic match_hit;
  logic [16:0] source_eff;
  logic [16:0] destination_eff;
  logic [16:0] cell_eff;
  logic [16:0] src_next;
  logic [16:0] dst_next;
  logic [16:0] cell_next;
  logic src_wrap;
  logic dst_wrap;
  logic cell_wrap;

  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wb_wr = wb_req & wb_we_i;

  // zero-size fields stand for 65536 bytes
  assign source_eff = {source_size_r == 16'h0000, source_size_r};
  assign destination_eff = {destination_size_r == 16'h0000, destination_size_r};
  assign cell_eff = {cell_size_r == 16'h0000, cell_size_r};

  // handshakes on both sides of the buffer
  assign src_ready = (count_r != (PTR_W+1)'(DEPTH));
  assign dst_valid = (count_r != '0);
  assign src_fire = src_valid & src_ready;
  assign dst_fire = dst_valid & dst_ready;
  assign dst_data = mem_r[rptr_r];

  // match only counts while pattern mode is on
  assign match_hit = src_fire & pattern_mode_r & (src_data[7:0] == pattern_match_value_r);

  // next counts and wrap detection
  assign src_next = {1'b0, source_position_r} + 17'h00001;
  assign dst_next = {1'b0, destination_position_r} + 17'h00001;
  assign cell_next = {1'b0, cell_progress_r} + 17'h00001;
  assign src_wrap = (src_next == source_eff);
  assign dst_wrap = (dst_next == destination_eff);
  assign cell_wrap = (cell_next == cell_eff);

  // ==========================================================
  // two-entry buffer
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wptr_r <= '0;
      rptr_r <= '0;
      count_r <= '0;
    end else begin
      if (src_fire) begin
        wptr_r <= (wptr_r == PTR_W'(DEPTH-1)) ? '0 : wptr_r + PTR_W'(1);
      end
      if (dst_fire) begin
        rptr_r <= (rptr_r == PTR_W'(DEPTH-1)) ? '0 : rptr_r + PTR_W'(1);
      end
      if (src_fire && !dst_fire) begin
        count_r <= count_r + (PTR_W+1)'(1);
      end else if (!src_fire && dst_fire) begin
        count_r <= count_r - (PTR_W+1)'(1);
      end
    end
  end

  // buffer entries, written on accept
  always_ff @(posedge clk) begin
    if (src_fire) begin
      mem_r[wptr_r] <= src_data;
    end
  end

  // ==========================================================
  // software-written fields
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      source_size_r <= RST_FIELD16;
      destination_size_r <= RST_FIELD16;
      cell_size_r <= RST_FIELD16;
      pattern_match_value_r <= RST_FIELD8;
      pattern_mode_r <= RST_BIT;
    end else if (wb_wr) begin
      // only the low lanes hold bits; upper lanes are dropped
      unique case (wb_adr_i)
        OFS_SOURCE_SIZE: begin
          if (wb_sel_i[0]) source_size_r[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) source_size_r[15:8] <= wb_dat_i[15:8];
        end
        OFS_DESTINATION_SIZE: begin
          if (wb_sel_i[0]) destination_size_r[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) destination_size_r[15:8] <= wb_dat_i[15:8];
        end
        OFS_CELL_SIZE: begin
          if (wb_sel_i[0]) cell_size_r[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) cell_size_r[15:8] <= wb_dat_i[15:8];
        end
        OFS_PATTERN_MATCH_VALUE: begin
          if (wb_sel_i[0]) pattern_match_value_r <= wb_dat_i[7:0];
        end
        OFS_CONTROL: begin
          if (wb_sel_i[0]) pattern_mode_r <= wb_dat_i[CTRL_PATTERN_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // source position: advances per accepted byte
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      source_position_r <= RST_FIELD16;
    end else if (match_hit) begin
      source_position_r <= RST_FIELD16;
    end else if (src_fire) begin
      source_position_r <= src_wrap ? RST_FIELD16 : src_next[15:0];
    end
  end

  // destination position: advances per delivered byte
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      destination_position_r <= RST_FIELD16;
    end else if (dst_fire) begin
      destination_position_r <= dst_wrap ? RST_FIELD16 : dst_next[15:0];
    end
  end

  // cell progress: bytes delivered since last trigger or pattern match, wrapping at cell size
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cell_progress_r <= RST_FIELD16;
    end else if (match_hit || trigger) begin
      cell_progress_r <= RST_FIELD16;
    end else if (dst_fire) begin
      cell_progress_r <= cell_wrap ? RST_FIELD16 : cell_next[15:0];
    end
  end

  // one-cycle event pulses
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pattern_match_r <= 1'b0;
      cell_done_r <= 1'b0;
      source_done_r <= 1'b0;
      destination_done_r <= 1'b0;
    end else begin
      pattern_match_r <= match_hit;
      cell_done_r <= dst_fire & cell_wrap & ~match_hit & ~trigger;
      source_done_r <= src_fire & src_wrap & ~match_hit;
      destination_done_r <= dst_fire & dst_wrap;
    end
  end

  assign pattern_match = pattern_match_r;
  assign cell_done = cell_done_r;
  assign source_done = source_done_r;
  assign destination_done = destination_done_r;

  // ==========================================================
  // wishbone answer: one wait state, upper half reads zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
      rdata_r <= UNMAPPED_READ;
    end else begin
      ack_r <= wb_req;
      if (wb_req) begin
        unique case (wb_adr_i)
          OFS_SOURCE_SIZE: rdata_r <= {16'h0000, source_size_r};
          OFS_DESTINATION_SIZE: rdata_r <= {16'h0000, destination_size_r};
          OFS_SOURCE_POSITION: rdata_r <= {16'h0000, source_position_r};
          OFS_DESTINATION_POSITION: rdata_r <= {16'h0000, destination_position_r};
          OFS_CELL_SIZE: rdata_r <= {16'h0000, cell_size_r};
          OFS_CELL_PROGRESS: rdata_r <= {16'h0000, cell_progress_r};
          OFS_PATTERN_MATCH_VALUE: rdata_r <= {24'h000000, pattern_match_value_r};
          OFS_CONTROL: rdata_r <= {31'h00000000, pattern_mode_r};
          default: rdata_r <= UNMAPPED_READ;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_cell_write;
    wb_wr && (wb_adr_i == OFS_CELL_SIZE) && (wb_sel_i == 4'hF);
  endsequence

  sequence s_pattern_hit;
    src_fire && pattern_mode_r && (src_data[7:0] == pattern_match_value_r);
  endsequence

  sequence s_src_read;
    wb_req && !wb_we_i && (wb_adr_i == OFS_SOURCE_POSITION);
  endsequence

  property p_pattern_clear;
    s_pattern_hit |=> (source_position_r == 16'h0000) && (cell_progress_r == 16'h0000) && pattern_match;
  endproperty
  a_pattern_clear: assert property (p_pattern_clear) else $error("pattern match did not clear counters");

  property p_src_step;
    (src_fire && !match_hit && !src_wrap) |=> (source_position_r == $past(source_position_r) + 16'h0001);
  endproperty
  a_src_step: assert property (p_src_step) else $error("source position did not step by one");

  property p_src_read;
    s_src_read ##1 wb_ack_o |-> (wb_dat_o == {16'h0000, source_position_r}) || $past(src_fire);
  endproperty
  a_src_read: assert property (p_src_read) else $error("source position read wrong");

  property p_dst_wrap;
    (dst_fire && dst_wrap) |=> (destination_position_r == 16'h0000) && destination_done;
  endproperty
  a_dst_wrap: assert property (p_dst_wrap) else $error("destination did not wrap at size");

  property p_dst_hold;
    !dst_fire |=> $stable(destination_position_r);
  endproperty
  a_dst_hold: assert property (p_dst_hold) else $error("destination moved without a byte");

  property p_src_wrap;
    (src_fire && src_wrap && !match_hit) |=> (source_position_r == 16'h0000) && source_done;
  endproperty
  a_src_wrap: assert property (p_src_wrap) else $error("source did not wrap at size");

  property p_cell_bound;
    ({1'b0, cell_progress_r} < cell_eff);
  endproperty
  a_cell_bound: assert property (p_cell_bound) else $error("cell progress passed cell size");

  property p_cell_write;
    s_cell_write |=> ({16'h0000, cell_size_r} == ($past(wb_dat_i) & DATA_LO_MASK));
  endproperty
  a_cell_write: assert property (p_cell_write) else $error("cell size write lost or upper bits kept");

  property p_no_match_off;
    !pattern_mode_r |=> !pattern_match;
  endproperty
  a_no_match_off: assert property (p_no_match_off) else $error("match reported outside pattern mode");

  property p_upper_zero;
    wb_ack_o |-> (wb_dat_o[31:16] == 16'h0000);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper half read nonzero");

  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

  property p_reset_zero;
    @(posedge clk) !rst_b |=> (source_position_r == 16'h0000) && (destination_position_r == 16'h0000)
      && (cell_size_r == 16'h0000) && (cell_progress_r == 16'h0000);
  endproperty
  a_reset_zero: assert property (disable iff (1'b0) p_reset_zero) else $error("fields not zero after reset");

  property p_trigger_clear;
    trigger |=> (cell_progress_r == 16'h0000);
  endproperty
  a_trigger_clear: assert property (p_trigger_clear) else $error("trigger did not clear cell progress");

  property p_dst_step;
    (dst_fire && !dst_wrap) |=> (destination_position_r == $past(destination_position_r) + 16'h0001);
  endproperty
  a_dst_step: assert property (p_dst_step) else $error("destination did not step by one");

endmodule

`default_nettype wire

// ===== dpt_partner.sv
// byte source and sink model standing on the far side of the channel stream ports
`timescale 1ns/1ps
`default_nettype none
module dpt_partner (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic stall,
  input wire logic src_ready,
  output var logic src_valid = 1'b0,
  output var logic [7:0] src_data = 8'h00,
  input wire logic dst_valid,
  output var logic dst_ready = 1'b0,
  input wire logic [7:0] dst_data
);
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  // queue a byte for the source side
  task send(input logic [7:0] b);
    tx_q.push_back(b);
  endtask
  // source side: hold a byte until taken, show a changed value while idle
  always @(posedge clk) begin
    if (!rst_b) begin
      src_valid <= 1'b0;
    end else begin
      if (src_valid && src_ready) begin
        void'(tx_q.pop_front());
      end
      src_valid <= (tx_q.size() != 0);
      src_data <= (tx_q.size() != 0) ? tx_q[0] : ~src_data;
    end
  end
  // sink side: collect bytes, stall on request
  always @(posedge clk) begin
    if (rst_b && dst_valid && dst_ready) begin
      rx_q.push_back(dst_data);
    end
    dst_ready <= rst_b && !stall;
  end
endmodule
`default_nettype wire

// ===== dpt_pkg.sv
// constants for the dma channel progress tracking block
package dpt_pkg;
  // ==========================================================
  // register bus
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_SOURCE_SIZE = 8'h00;
  localparam logic [7:0] OFS_DESTINATION_SIZE = 8'h04;
  localparam logic [7:0] OFS_SOURCE_POSITION = 8'h08;
  localparam logic [7:0] OFS_DESTINATION_POSITION = 8'h0C;
  localparam logic [7:0] OFS_CELL_SIZE = 8'h10;
  localparam logic [7:0] OFS_CELL_PROGRESS = 8'h14;
  localparam logic [7:0] OFS_PATTERN_MATCH_VALUE = 8'h18;
  localparam logic [7:0] OFS_CONTROL = 8'h1C;
  // ==========================================================
  // fields and reset values
  localparam int POS_W = 16;
  localparam int CTRL_PATTERN_BIT = 0;
  localparam logic [15:0] RST_FIELD16 = 16'h0000;
  localparam logic [7:0] RST_FIELD8 = 8'h00;
  localparam logic RST_BIT = 1'b0;
  localparam logic [31:0] DATA_LO_MASK = 32'h0000FFFF;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
  // ==========================================================
  // buffer
  localparam int BUF_DEPTH = 2;
  localparam int DATA_W = 8;
endpackage

// ===== tb_top.sv
// testbench for the channel progress tracking block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dpt_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, trigger = 1'b0, stall = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_i = 32'h0;
  wire logic [31:0] dat_o;
  wire logic ack, src_valid, src_ready, dst_valid, dst_ready;
  wire logic [7:0] src_data, dst_data;
  wire logic pm, cdone, sdone, ddone;
  int n_pm = 0, n_cdone = 0, n_sdone = 0, n_ddone = 0;
  int err_count = 0;
  int n_checks = 0;
  // ==========================================================
  // clock and instances
  initial forever #5 clk = ~clk;
  dpt_channel dpt_channel_i (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack), .trigger(trigger),
    .src_valid(src_valid), .src_ready(src_ready), .src_data(src_data), .dst_valid(dst_valid),
    .dst_ready(dst_ready), .dst_data(dst_data), .pattern_match(pm), .cell_done(cdone), .source_done(sdone),
    .destination_done(ddone));
  dpt_partner dpt_partner_i (.clk(clk), .rst_b(rst_b), .stall(stall), .src_ready(src_ready),
    .src_valid(src_valid), .src_data(src_data), .dst_valid(dst_valid), .dst_ready(dst_ready),
    .dst_data(dst_data));
  // count the one-cycle event pulses, each seen once at the edge after it is launched
  always @(posedge clk) begin
    if (rst_b === 1'b1) begin
      if (pm === 1'b1) n_pm++;
      if (cdone === 1'b1) n_cdone++;
      if (sdone === 1'b1) n_sdone++;
      if (ddone === 1'b1) n_ddone++;
    end
  end
  // ==========================================================
  // shared tasks
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one classic wishbone cycle, held until ack is sampled high
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_i <= d;
    sel <= 4'hF;
    // wait for the answer however long it takes; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(what, q, exp);
  endtask
  // wait until the partner has sent everything and the buffer is empty
  task drain;
    int n;
    for (n = 0; n < 200 && (dpt_partner_i.tx_q.size() != 0 || dst_valid !== 1'b0); n++) @(posedge clk);
    if (n >= 200) err_count++;
    repeat (3) @(posedge clk);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========================================================
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up();
  end
  // ==========================================================
  // tests
  initial begin
    int i;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    // reset values and unmapped place
    rd_chk("source_position", OFS_SOURCE_POSITION, 32'h0);
    rd_chk("destination_position", OFS_DESTINATION_POSITION, 32'h0);
    rd_chk("cell_size", OFS_CELL_SIZE, 32'h0);
    rd_chk("cell_progress", OFS_CELL_PROGRESS, 32'h0);
    rd_chk("unmapped", 8'hF0, UNMAPPED_READ);
    $display("test reset done");
    // upper half ignored, read-only places ignore writes
    wr(OFS_CELL_SIZE, 32'hFFFF0002);
    wr(OFS_SOURCE_POSITION, 32'h00001234);
    wr(OFS_CELL_PROGRESS, 32'h00000001);
    rd_chk("cell_size", OFS_CELL_SIZE, 32'h00000002);
    rd_chk("source_position", OFS_SOURCE_POSITION, 32'h0);
    rd_chk("cell_progress", OFS_CELL_PROGRESS, 32'h0);
    $display("test access done");
    // stream with a stalled sink, then drained
    wr(OFS_SOURCE_SIZE, 32'h00000004);
    wr(OFS_DESTINATION_SIZE, 32'h00000006);
    stall <= 1'b1;
    for (i = 1; i <= 5; i++) dpt_partner_i.send(i[7:0]);
    repeat (8) @(posedge clk);
    check("src_ready full", {31'h0, src_ready}, 32'h0);
    rd_chk("source_position stalled", OFS_SOURCE_POSITION, 32'h00000002);
    rd_chk("destination_position stalled", OFS_DESTINATION_POSITION, 32'h0);
    stall <= 1'b0;
    drain();
    rd_chk("source_position", OFS_SOURCE_POSITION, 32'h00000001);
    rd_chk("destination_position", OFS_DESTINATION_POSITION, 32'h00000005);
    rd_chk("cell_progress", OFS_CELL_PROGRESS, 32'h00000001);
    for (i = 0; i < 5; i++) check("dst byte", {24'h0, dpt_partner_i.rx_q[i]}, i + 1);
    $display("test stream done");
    // trigger restarts the cell count
    @(posedge clk);
    trigger <= 1'b1;
    @(posedge clk);
    trigger <= 1'b0;
    rd_chk("cell_progress trigger", OFS_CELL_PROGRESS, 32'h0);
    $display("test trigger done");
    // pattern value ignored outside pattern mode, clears source position inside it
    wr(OFS_PATTERN_MATCH_VALUE, 32'h000000A5);
    wr(OFS_CONTROL, 32'h0);
    dpt_partner_i.send(8'hA5);
    drain();
    rd_chk("source_position no mode", OFS_SOURCE_POSITION, 32'h00000002);
    wr(OFS_CONTROL, 32'h00000001);
    dpt_partner_i.send(8'h07);
    dpt_partner_i.send(8'hA5);
    drain();
    rd_chk("source_position match", OFS_SOURCE_POSITION, 32'h0);
    rd_chk("destination_position", OFS_DESTINATION_POSITION, 32'h00000002);
    check("dst byte match", {24'h0, dpt_partner_i.rx_q[7]}, 32'h000000A5);
    check("pattern_match pulses", n_pm, 32'h00000001);
    check("cell_done pulses", n_cdone, 32'h00000002);
    check("source_done pulses", n_sdone, 32'h00000001);
    check("destination_done pulses", n_ddone, 32'h00000001);
    $display("test pattern done");
    wrap_up();
  end
endmodule
`default_nettype wire
